/* File: rtl/dvtg_pkg.sv */
// Shared constants and types for the demodulation valid and trigger gate block
package dvtg_pkg;
	localparam int DVTG_SLOTS = 8;
	localparam int DVTG_SLOT_W = 3;
	localparam int DVTG_BITCNT_W = 8;
	// Burst section lengths in bits, normal burst layout by default
	localparam logic [7:0] DVTG_TAIL_BITS = 8'h03;
	localparam logic [7:0] DVTG_NB_DATA_BITS = 8'h3A;
	localparam logic [7:0] DVTG_NB_MID_BITS = 8'h1A;
	localparam logic [7:0] DVTG_AB_DATA_BITS = 8'h24;
	localparam logic [7:0] DVTG_AB_MID_BITS = 8'h29;
	localparam logic [7:0] DVTG_AB_TAIL2_BITS = 8'h03;
	localparam logic [7:0] DVTG_SB_DATA_BITS = 8'h27;
	localparam logic [7:0] DVTG_SB_MID_BITS = 8'h40;
	// Output bit clock divider: system clocks per demodulated bit
	localparam logic [7:0] DVTG_BIT_DIV = 8'h04;
	localparam logic DVTG_RST_LEVEL = 1'b0;
	// Trigger source selections
	typedef enum logic [1:0] {
		DVTG_TRIG_FREE = 2'h0,
		DVTG_TRIG_RF = 2'h1,
		DVTG_TRIG_EXT = 2'h2,
		DVTG_TRIG_PROT = 2'h3
	} dvtg_trig_e;
	// Burst types
	typedef enum logic [1:0] {
		DVTG_BURST_NORMAL = 2'h0,
		DVTG_BURST_SYNC = 2'h1,
		DVTG_BURST_ACCESS = 2'h2
	} dvtg_burst_e;
	// Burst sections, Gray coded in order of travel
	typedef enum logic [2:0] {
		DVTG_SEC_IDLE = 3'h0,
		DVTG_SEC_TAIL1 = 3'h1,
		DVTG_SEC_DATA1 = 3'h3,
		DVTG_SEC_MID = 3'h2,
		DVTG_SEC_DATA2 = 3'h6,
		DVTG_SEC_TAIL2 = 3'h7,
		DVTG_SEC_GUARD = 3'h5
	} dvtg_sec_e;
endpackage

/* File: rtl/dvtg_sync_if.sv */
// Interface carrying synchronised external inputs between block modules
`timescale 1ns/1ps
interface dvtg_sync_if;
	logic trig_lvl;
	logic trig_rise;
	logic pulse_lvl;
	modport src (output trig_lvl, output trig_rise, output pulse_lvl);
	modport dst (input trig_lvl, input trig_rise, input pulse_lvl);
endinterface

/* File: rtl/dvtg_in_sync.sv */
// Two-stage synchronisers and trigger edge detect for external inputs
`timescale 1ns/1ps
module dvtg_in_sync
	import dvtg_pkg::*;
(
	input wire logic i_mclk, // System clock
	input wire logic i_reset, // Synchronous reset
	input wire logic i_trig_in, // External measurement trigger pin
	input wire logic i_pulse_in, // External pulse modulation pin
	dvtg_sync_if.src sync // Synchronised levels and trigger edge
);
	logic [1:0] trig_sh_r;
	logic [1:0] pulse_sh_r;
	logic trig_last_r;

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			trig_sh_r <= 2'h0;
			pulse_sh_r <= 2'h0;
			trig_last_r <= 1'b0;
		end else begin
			trig_sh_r <= {trig_sh_r[0], i_trig_in};
			pulse_sh_r <= {pulse_sh_r[0], i_pulse_in};
			trig_last_r <= trig_sh_r[1];
		end
	end

	assign sync.trig_lvl = trig_sh_r[1];
	assign sync.pulse_lvl = pulse_sh_r[1];
	assign sync.trig_rise = trig_sh_r[1] & ~trig_last_r;
endmodule

/* File: rtl/dvtg_top.sv */
// Trigger routing, pulse amplitude gating and demodulation data valid strobe
`timescale 1ns/1ps
module dvtg_top
	import dvtg_pkg::*;
#(
	parameter int BIT_DIV = 4
) (
	input wire logic i_mclk, // 10 MHz system clock
	input wire logic i_reset, // Synchronous reset, active high
	input wire logic i_trig_in, // External measurement trigger pin
	input wire logic i_pulse_in, // External pulse modulation pin
	input wire logic i_pulse_ext_sel, // Pulse modulation source set to external
	input wire logic i_pulse_30db, // 30 dB pulse mode
	input wire logic [1:0] i_demod_trig_src, // Demodulator trigger source
	input wire logic [1:0] i_sync_trig_src, // Measurement sync trigger source
	input wire logic i_int_trig, // Internal trigger event for non-external sources
	input wire logic i_demod_sel, // Digital demodulation mode selected
	input wire logic i_demod_arm, // Digital demodulation armed
	input wire logic [2:0] i_slot_sel, // Timeslot to demodulate
	input wire logic [2:0] i_slot_now, // Current timeslot number
	input wire logic [1:0] i_burst_type, // Burst type being demodulated
	input wire logic i_demod_done, // Demodulation computation finished
	input wire logic i_demod_bit, // Next demodulated bit to shift out
	output logic o_rf_on, // RF amplitude gate, high is on
	output logic o_env_high, // Envelope at higher level in 30 dB mode
	output logic o_meas_trig, // Shared measurement trigger pulse
	output logic o_demod_start, // Start of demodulation capture
	output logic o_demod_data, // Demodulated data output
	output logic o_demod_clk, // Demodulated data bit clock
	output logic o_valid_n, // Front connector data valid, active low
	output logic o_system_bus_data_valid_line_n // System bus data valid, active low
);
	initial begin
		if (BIT_DIV < 2 || BIT_DIV > 255) begin
			$error("BIT_DIV out of range");
		end
		// Refuse table values that the slot compare or section counter cannot serve
		if (DVTG_SLOTS != (1 << DVTG_SLOT_W)) begin
			$error("Slot count does not match slot field width");
		end
		if (DVTG_TAIL_BITS == 8'h00 || DVTG_AB_TAIL2_BITS == 8'h00) begin
			$error("Burst tail length must be nonzero");
		end
		if (DVTG_NB_DATA_BITS == 8'h00 || DVTG_SB_DATA_BITS == 8'h00 ||
				DVTG_AB_DATA_BITS == 8'h00) begin
			$error("Burst data length must be nonzero");
		end
		if (DVTG_NB_MID_BITS == 8'h00 || DVTG_SB_MID_BITS == 8'h00 ||
				DVTG_AB_MID_BITS == 8'h00) begin
			$error("Burst midamble length must be nonzero");
		end
	end

	dvtg_sync_if sync_if ();

	dvtg_in_sync u_sync (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_trig_in(i_trig_in),
		.i_pulse_in(i_pulse_in),
		.sync(sync_if.src)
	);

	// Trigger routing
	wire demod_ext = (i_demod_trig_src == DVTG_TRIG_EXT);
	wire meas_ext = (i_sync_trig_src == DVTG_TRIG_EXT);
	wire ext_used = demod_ext | meas_ext;
	wire ext_evt = ext_used & sync_if.trig_rise;
	wire meas_evt = meas_ext ? ext_evt : i_int_trig;
	wire demod_evt = demod_ext ? ext_evt : i_int_trig;

	// Pulse modulation
	wire pulse_lvl = i_pulse_ext_sel ? sync_if.pulse_lvl : 1'b1;
	wire rf_on_nxt = i_pulse_30db ? 1'b1 : pulse_lvl;
	wire env_high_nxt = i_pulse_30db ? pulse_lvl : 1'b1;

	// Demodulation output sequencer
	typedef enum logic [1:0] {
		DVTG_ST_IDLE = 2'h0,
		DVTG_ST_WAIT = 2'h1,
		DVTG_ST_CALC = 2'h3,
		DVTG_ST_SHIFT = 2'h2
	} dvtg_state_e;

	dvtg_state_e state_r;
	dvtg_state_e state_nxt;
	dvtg_sec_e sec_r;
	dvtg_sec_e sec_nxt;
	logic [7:0] bitcnt_r;
	logic [7:0] bitcnt_nxt;
	logic [7:0] div_r;
	logic [7:0] sec_len;
	logic [7:0] data_len;
	logic [7:0] mid_len;
	logic [7:0] tail2_len;
	logic valid_n_r;
	logic data_r;
	logic clk_r;
	logic rf_on_r;
	logic env_high_r;
	logic trig_r;
	logic start_r;

	wire armed = i_demod_sel & i_demod_arm;
	wire slot_hit = (i_slot_now == i_slot_sel);
	wire bit_tick = (state_r == DVTG_ST_SHIFT) && (div_r == 8'(BIT_DIV - 1));
	wire half_tick = (state_r == DVTG_ST_SHIFT) && (div_r == 8'(BIT_DIV / 2 - 1));
	wire sec_end = bit_tick && (bitcnt_r == sec_len - 8'h01);
	wire sec_shows = (sec_r != DVTG_SEC_IDLE) && (sec_r != DVTG_SEC_GUARD);

	// Section lengths by burst type
	always_comb begin
		data_len = DVTG_NB_DATA_BITS;
		mid_len = DVTG_NB_MID_BITS;
		tail2_len = DVTG_TAIL_BITS;
		unique case (i_burst_type)
			DVTG_BURST_SYNC: begin
				data_len = DVTG_SB_DATA_BITS;
				mid_len = DVTG_SB_MID_BITS;
			end
			DVTG_BURST_ACCESS: begin
				data_len = DVTG_AB_DATA_BITS;
				mid_len = DVTG_AB_MID_BITS;
				tail2_len = DVTG_AB_TAIL2_BITS;
			end
			default: begin
				data_len = DVTG_NB_DATA_BITS;
			end
		endcase
	end

	always_comb begin
		sec_len = DVTG_TAIL_BITS;
		unique case (sec_r)
			DVTG_SEC_DATA1, DVTG_SEC_DATA2: sec_len = data_len;
			DVTG_SEC_MID: sec_len = mid_len;
			DVTG_SEC_TAIL2: sec_len = tail2_len;
			default: sec_len = DVTG_TAIL_BITS;
		endcase
	end

	always_comb begin
		state_nxt = state_r;
		sec_nxt = sec_r;
		bitcnt_nxt = bitcnt_r;
		if (!armed) begin
			state_nxt = DVTG_ST_IDLE;
			sec_nxt = DVTG_SEC_IDLE;
			bitcnt_nxt = 8'h00;
		end else begin
			unique case (state_r)
				DVTG_ST_IDLE: state_nxt = DVTG_ST_WAIT;
				DVTG_ST_WAIT: begin
					if (demod_evt && slot_hit) begin
						state_nxt = DVTG_ST_CALC;
					end
				end
				DVTG_ST_CALC: begin
					if (i_demod_done) begin
						state_nxt = DVTG_ST_SHIFT;
						sec_nxt = DVTG_SEC_TAIL1;
						bitcnt_nxt = 8'h00;
					end
				end
				DVTG_ST_SHIFT: begin
					if (bit_tick) begin
						bitcnt_nxt = sec_end ? 8'h00 : bitcnt_r + 8'h01;
					end
					if (sec_end) begin
						unique case (sec_r)
							DVTG_SEC_TAIL1: sec_nxt = DVTG_SEC_DATA1;
							DVTG_SEC_DATA1: sec_nxt = DVTG_SEC_MID;
							DVTG_SEC_MID: sec_nxt = DVTG_SEC_DATA2;
							DVTG_SEC_DATA2: sec_nxt = DVTG_SEC_TAIL2;
							default: begin
								sec_nxt = DVTG_SEC_GUARD;
								state_nxt = DVTG_ST_WAIT;
							end
						endcase
					end
				end
			endcase
		end
	end

	// Divider restarts in the first shift cycle so every bit lasts BIT_DIV clocks
	wire [7:0] div_nxt = (state_r != DVTG_ST_SHIFT || bit_tick) ? 8'h00 : div_r + 8'h01;
	wire valid_nxt = armed && (state_r == DVTG_ST_SHIFT) && sec_shows;
	wire data_load = (div_r == 8'h00) && (state_r == DVTG_ST_SHIFT);
	wire clk_nxt = (state_r == DVTG_ST_SHIFT) && (half_tick || (clk_r && !bit_tick));
	wire start_nxt = (state_r == DVTG_ST_WAIT) && demod_evt && slot_hit && armed;

	// Sequencer state registers
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			state_r <= DVTG_ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			sec_r <= DVTG_SEC_IDLE;
		end else begin
			sec_r <= sec_nxt;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			bitcnt_r <= 8'h00;
		end else begin
			bitcnt_r <= bitcnt_nxt;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			div_r <= 8'h00;
		end else begin
			div_r <= div_nxt;
		end
	end

	// Output registers, each output straight from a flop, both valid outputs from the one valid_n_r flop
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			valid_n_r <= ~DVTG_RST_LEVEL;
		end else begin
			valid_n_r <= ~valid_nxt;
		end
	end

	// Data bit taken at the start of each bit period
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			data_r <= 1'b0;
		end else if (data_load) begin
			data_r <= i_demod_bit;
		end
	end

	// Bit clock rises mid-bit so the far side samples settled data
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			clk_r <= 1'b0;
		end else begin
			clk_r <= clk_nxt;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			rf_on_r <= 1'b0;
		end else begin
			rf_on_r <= rf_on_nxt;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			env_high_r <= 1'b0;
		end else begin
			env_high_r <= env_high_nxt;
		end
	end

	// Demod start is a one-cycle pulse; shared trigger is one cycle per pin edge, else follows i_int_trig
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			trig_r <= 1'b0;
		end else begin
			trig_r <= meas_evt;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			start_r <= 1'b0;
		end else begin
			start_r <= start_nxt;
		end
	end

	assign o_valid_n = valid_n_r;
	assign o_system_bus_data_valid_line_n = valid_n_r;
	assign o_demod_data = data_r;
	assign o_demod_clk = clk_r;
	assign o_rf_on = rf_on_r;
	assign o_env_high = env_high_r;
	assign o_meas_trig = trig_r;
	assign o_demod_start = start_r;
endmodule

/* File: dv/dvtg_top_sva.sv */
// Concurrent checks on the trigger, pulse and data valid ports
`timescale 1ns/1ps
module dvtg_top_sva
	import dvtg_pkg::*;
#(
	parameter int BIT_DIV = 4
) (
	input wire logic i_mclk, // Clock
	input wire logic i_reset, // Reset
	input wire logic i_trig_in, // Trigger pin
	input wire logic i_pulse_in, // Pulse pin
	input wire logic i_pulse_ext_sel, // Pulse external
	input wire logic i_pulse_30db, // 30 dB mode
	input wire logic [1:0] i_demod_trig_src, // Demod source
	input wire logic [1:0] i_sync_trig_src, // Sync source
	input wire logic i_int_trig, // Internal trigger
	input wire logic i_demod_sel, // Demod selected
	input wire logic i_demod_arm, // Demod armed
	input wire logic [2:0] i_slot_sel, // Slot wanted
	input wire logic [2:0] i_slot_now, // Slot now
	input wire logic [1:0] i_burst_type, // Burst type
	input wire logic o_rf_on, // RF gate
	input wire logic o_env_high, // Envelope level
	input wire logic o_meas_trig, // Shared trigger
	input wire logic o_demod_start, // Demod start
	input wire logic o_demod_clk, // Bit clock
	input wire logic o_valid_n, // Front valid
	input wire logic o_system_bus_data_valid_line_n // Bus valid
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_reset);
	logic [11:0] lo_r;
	logic [11:0] lo_nxt;
	assign lo_nxt = o_valid_n ? 12'h000 : lo_r + 12'h001;
	always_ff @(posedge i_mclk) lo_r <= lo_nxt;
	valid_pair_a: assert property (o_valid_n == o_system_bus_data_valid_line_n)
		else $error("valid lines differ");
	rf_high_a: assert property ((i_pulse_ext_sel && !i_pulse_30db && i_pulse_in)[*5] |-> o_rf_on)
		else $error("rf not on");
	rf_low_a: assert property ((i_pulse_ext_sel && !i_pulse_30db && !i_pulse_in)[*5] |-> !o_rf_on)
		else $error("rf not off");
	env_step_a: assert property ((i_pulse_30db && i_pulse_ext_sel && $stable(i_pulse_in))[*5]
		|-> o_rf_on && o_env_high == i_pulse_in) else $error("envelope wrong");
	trig_ext_a: assert property (($rose(i_trig_in) && i_sync_trig_src == DVTG_TRIG_EXT)
		|-> ##3 o_meas_trig) else $error("trigger missed");
	ext_only_a: assert property ((i_sync_trig_src == DVTG_TRIG_EXT && !i_trig_in)[*6]
		|-> !o_meas_trig) else $error("trigger from other source");
	ext_unused_a: assert property ((i_sync_trig_src != DVTG_TRIG_EXT &&
		i_demod_trig_src != DVTG_TRIG_EXT && !i_int_trig)[*6] |-> !o_meas_trig)
		else $error("trigger without event");
	idle_valid_a: assert property (!(i_demod_sel && i_demod_arm) |=> o_valid_n)
		else $error("valid while idle");
	burst_len_a: assert property ($rose(o_valid_n) && i_demod_arm && i_demod_sel |->
		lo_r == 12'(((i_burst_type == DVTG_BURST_ACCESS) ? 119 : 148) * BIT_DIV))
		else $error("valid length wrong");
	clk_gate_a: assert property (o_demod_clk |-> !o_valid_n)
		else $error("bit clock outside valid");
	slot_start_a: assert property (o_demod_start |-> $past(i_slot_sel == i_slot_now && i_demod_arm))
		else $error("start on wrong slot");
	cover property ($rose(o_valid_n) && i_demod_arm);
	cover property (o_meas_trig);
	cover property ($fell(o_rf_on));
endmodule
bind dvtg_top dvtg_top_sva #(.BIT_DIV(BIT_DIV)) chk_u (.i_mclk, .i_reset, .i_trig_in, .i_pulse_in,
	.i_pulse_ext_sel, .i_pulse_30db, .i_demod_trig_src, .i_sync_trig_src, .i_int_trig,
	.i_demod_sel, .i_demod_arm, .i_slot_sel, .i_slot_now, .i_burst_type, .o_rf_on, .o_env_high,
	.o_meas_trig, .o_demod_start, .o_demod_clk, .o_valid_n, .o_system_bus_data_valid_line_n);

/* File: dv/dvtg_capture.sv */
// Capture equipment model loading demodulated bits inside the valid window
`timescale 1ns/1ps
module dvtg_capture (
	input wire logic i_mclk, // Clock
	input wire logic i_valid_n, // Valid strobe
	input wire logic i_bit_clk, // Bit clock
	output int o_bits // Bits loaded
);
	logic clk_q = 1'b0;
	initial o_bits = 0;
	always @(posedge i_mclk) begin
		clk_q <= i_bit_clk;
		if (i_bit_clk && !clk_q && !i_valid_n) o_bits <= o_bits + 1;
	end
endmodule

/* File: dv/tb.sv */
// Directed testbench for the trigger, pulse and data valid gate
`timescale 1ns/1ps
module tb;
	import dvtg_pkg::*;
	logic i_mclk = 1'b0, i_reset = 1'b1, i_trig_in = 1'b0, i_pulse_in = 1'b0;
	logic i_pulse_ext_sel = 1'b0, i_pulse_30db = 1'b0, i_int_trig = 1'b0, i_demod_sel = 1'b0;
	logic i_demod_arm = 1'b0, i_demod_done = 1'b0, i_demod_bit = 1'b0;
	logic [1:0] i_demod_trig_src = 2'h0, i_sync_trig_src = 2'h0, i_burst_type = 2'h0;
	logic [2:0] i_slot_sel = 3'h5, i_slot_now = 3'h5;
	logic o_rf_on, o_env_high, o_meas_trig, o_demod_start, o_demod_data, o_demod_clk, o_valid_n;
	logic o_system_bus_data_valid_line_n;
	int fail_count = 0, total_checks = 0, cap_bits, got, st;
	dvtg_top #(.BIT_DIV(4)) dut_u (.i_mclk, .i_reset, .i_trig_in, .i_pulse_in, .i_pulse_ext_sel,
		.i_pulse_30db, .i_demod_trig_src, .i_sync_trig_src, .i_int_trig, .i_demod_sel,
		.i_demod_arm, .i_slot_sel, .i_slot_now, .i_burst_type, .i_demod_done, .i_demod_bit,
		.o_rf_on, .o_env_high, .o_meas_trig, .o_demod_start, .o_demod_data, .o_demod_clk,
		.o_valid_n, .o_system_bus_data_valid_line_n);
	dvtg_capture cap_u (.i_mclk, .i_valid_n(o_valid_n), .i_bit_clk(o_demod_clk), .o_bits(cap_bits));
	always #50 i_mclk = ~i_mclk;
	always @(posedge i_mclk) i_demod_bit <= ~i_demod_bit;
	task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %0h seen %0h", name, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic cyc(input int c);
		repeat (c) @(negedge i_mclk);
	endtask
	task automatic bound(input int c);
		if (c >= 2000) begin
			fail_count++;
			print_verdict();
		end
	endtask
	// Raise the trigger pin and count shared trigger and demod start pulses
	task automatic pulse_trig();
		got = 0;
		st = 0;
		@(posedge i_mclk) i_trig_in <= 1'b1;
		repeat (8) begin
			@(negedge i_mclk);
			got += (o_meas_trig === 1'b1);
			st += (o_demod_start === 1'b1);
		end
		@(posedge i_mclk) i_trig_in <= 1'b0;
	endtask
	task automatic burst(input logic [1:0] bt, input int nbits, input bit abort);
		int k, n, b0;
		@(posedge i_mclk) i_burst_type <= bt;
		pulse_trig();
		chk("demod start", 12'(st), 12'h001);
		@(posedge i_mclk) i_demod_done <= 1'b1;
		@(posedge i_mclk) i_demod_done <= 1'b0;
		b0 = cap_bits;
		for (k = 0; o_valid_n !== 1'b0 && k < 2000; k++) cyc(1);
		bound(k);
		chk("first bit", 12'(o_demod_data), 12'(!i_demod_bit));
		if (abort) begin
			@(posedge i_mclk) i_demod_arm <= 1'b0;
			cyc(2);
			chk("valid after disarm", 12'(o_valid_n), 12'h001);
			$display("abort test done");
			return;
		end
		for (n = 0; o_valid_n === 1'b0 && n < 2000; n++) cyc(1);
		bound(n);
		chk("valid length", 12'(n), 12'(nbits * 4));
		chk("bits loaded", 12'(cap_bits - b0), 12'(nbits));
		$display("burst type %0d done", bt);
	endtask
	initial begin
		@(posedge i_mclk);
		@(posedge i_mclk) i_reset <= 1'b0;
		cyc(1);
		chk("valid idle", 12'({o_valid_n, o_system_bus_data_valid_line_n}), 12'h003);
		@(posedge i_mclk) i_pulse_ext_sel <= 1'b1;
		i_pulse_in <= 1'b1;
		cyc(6);
		chk("rf on", 12'(o_rf_on), 12'h001);
		@(posedge i_mclk) i_pulse_in <= 1'b0;
		cyc(6);
		chk("rf off", 12'(o_rf_on), 12'h000);
		@(posedge i_mclk) i_pulse_30db <= 1'b1;
		cyc(6);
		chk("env low", 12'({o_rf_on, o_env_high}), 12'h002);
		@(posedge i_mclk) i_pulse_in <= 1'b1;
		cyc(6);
		chk("env high", 12'({o_rf_on, o_env_high}), 12'h003);
		$display("pulse test done");
		@(posedge i_mclk) i_sync_trig_src <= DVTG_TRIG_EXT;
		pulse_trig();
		chk("ext trigger", 12'(got), 12'h001);
		@(posedge i_mclk) i_int_trig <= 1'b1;
		@(posedge i_mclk) i_int_trig <= 1'b0;
		@(negedge i_mclk) chk("int ignored", 12'(o_meas_trig), 12'h000);
		@(posedge i_mclk) i_sync_trig_src <= DVTG_TRIG_FREE;
		cyc(8);
		pulse_trig();
		chk("pin ignored", 12'(got), 12'h000);
		$display("trigger test done");
		@(posedge i_mclk) i_demod_trig_src <= DVTG_TRIG_EXT;
		i_demod_sel <= 1'b1;
		i_demod_arm <= 1'b1;
		burst(DVTG_BURST_NORMAL, 148, 1'b0);
		burst(DVTG_BURST_SYNC, 148, 1'b0);
		burst(DVTG_BURST_ACCESS, 119, 1'b0);
		@(posedge i_mclk) i_slot_now <= 3'h2;
		pulse_trig();
		chk("wrong slot start", 12'(st), 12'h000);
		@(posedge i_mclk) i_slot_now <= 3'h5;
		burst(DVTG_BURST_NORMAL, 148, 1'b1);
		$display("demod test done");
		print_verdict();
	end
endmodule
